// ---- include/sspam_pkg.sv ----
// Constants and types for the second serial port with address match
// ============================================================
// Functional notes
// - Two mode bits choose shift, 10-bit variable, 11-bit fixed or 11-bit variable frames.
// - Control bit 7 is upper mode bit or sticky framing error, per selector input.
// - Modes 2/3 with multiprocessor enable: ninth bit 0 never raises receive-complete.
// - Mode 1 with multiprocessor enable: receive-complete needs a valid stop bit.
// - Mode 0 shift clock is clock/12, or clock/4 when multiprocessor enable is set.
// - Receiver works only while receive enable is set; otherwise line is ignored.
// - Modes 2/3 transmit the software ninth bit as ninth data bit.
// - Received ninth bit holds ninth bit (modes 2/3) or stop bit (mode 1).
// - Transmit-complete sets after eighth bit (mode 0) or at stop start; software clears.
// - Receive-complete sets after eighth bit (mode 0) or mid stop bit; software clears.
// - Data address: reads return receive register, writes load transmit buffer.
// - Mask bits at 1 compare slave-address bits; mask bits at 0 are don't-care.
// - An all-zero mask accepts every incoming address.
// - Transmit activity is high during a frame, cleared when transmit-complete sets.
// - Receive activity is high during a frame, cleared when receive-complete sets.
package sspam_pkg;
    // ============================================================
    // Register addresses on the special-function bus
    localparam logic [7:0] ADDR_SLAVE = 8'hAA;
    localparam logic [7:0] ADDR_MASK = 8'hBA;
    localparam logic [7:0] ADDR_CONTROL = 8'hC0;
    localparam logic [7:0] ADDR_DATA = 8'hC1;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ============================================================
    // Control register bit positions
    localparam int CTL_UPPER_MODE = 7;
    localparam int CTL_LOWER_MODE = 6;
    localparam int CTL_MP_EN = 5;
    localparam int CTL_RX_EN = 4;
    localparam int CTL_TX_NINTH = 3;
    localparam int CTL_RX_NINTH = 2;
    localparam int CTL_TX_DONE = 1;
    localparam int CTL_RX_DONE = 0;
    // ============================================================
    // Timing: sixteen sub-ticks per async bit, sampled at the centre
    localparam logic [3:0] SUB_LAST = 4'hF;
    localparam logic [3:0] SAMPLE_POINT = 4'h7;
    localparam logic [1:0] M2_DIV_SLOW = 2'h3;
    localparam logic [1:0] M2_DIV_FAST = 2'h1;
    localparam logic [3:0] M0_LAST_SLOW = 4'hB;
    localparam logic [3:0] M0_LAST_FAST = 4'h3;
    localparam logic [3:0] M0_HALF_SLOW = 4'h6;
    localparam logic [3:0] M0_HALF_FAST = 4'h2;
    localparam logic [3:0] LAST_BIT_SHORT = 4'h9;
    localparam logic [3:0] LAST_BIT_LONG = 4'hA;
    localparam logic [3:0] SYNC_LAST = 4'h7;
    // ============================================================
    // Modes and engine states
    typedef enum logic [1:0] {MODE_SHIFT, MODE_VAR8, MODE_FIX9, MODE_VAR9} sspam_mode_t;
    typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} sspam_tx_t;
    typedef enum logic [1:0] {RX_IDLE, RX_ASYNC, RX_SYNC} sspam_rx_t;
endpackage : sspam_pkg

// ---- logic/sspam_core.sv ----
// Second serial port: register file, transmitter, receiver, address match
`timescale 1ns/1ps
module sspam_core
    import sspam_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWr,
    input wire logic sfrRd,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    input wire logic frameErrSel,
    input wire logic doubleRate,
    input wire logic baudTick,
    input wire logic rxdIn,
    output logic rxdOut,
    output logic rxdOe,
    output logic txdOut,
    output logic txActive,
    output logic rxActive
);
    typedef struct packed {
        logic [7:0] ctl;
        logic frameErr;
        logic [7:0] mask;
        logic [7:0] slave;
        logic [7:0] rxData;
        logic [7:0] rdata;
        sspam_tx_t tx;
        logic [10:0] txShift;
        logic [3:0] txCnt;
        logic [3:0] txSub;
        logic txAct;
        sspam_rx_t rx;
        logic [8:0] rxShift;
        logic [3:0] rxCnt;
        logic [3:0] rxSub;
        logic rxAct;
        logic rxPrev;
        logic [1:0] subDiv;
        logic [3:0] syncDiv;
        logic txdLine;
    } sspam_state_t;

    sspam_state_t s;
    sspam_state_t next_s;
    sspam_mode_t mode;
    logic nineBit;
    logic subTick;
    logic rxFinish;
    logic stopBit;
    logic ninthBit;
    logic addrOk;
    logic accept;
    logic txStopEntry;
    logic [7:0] rxWord;
    logic [3:0] lastBit;
    logic [3:0] syncLast;
    logic [3:0] syncHalf;

    // ============================================================
    // Outputs straight from state flops
    assign sfrRdata = s.rdata;
    assign txdOut = s.txdLine;
    assign rxdOut = s.txShift[0];
    assign rxdOe = (s.tx == TX_SYNC);
    assign txActive = s.txAct;
    assign rxActive = s.rxAct;

    // ============================================================
    // Next-state logic for the whole port
    always_comb
    begin
        next_s = s;
        mode = sspam_mode_t'({s.ctl[CTL_UPPER_MODE], s.ctl[CTL_LOWER_MODE]});
        nineBit = (mode == MODE_FIX9) || (mode == MODE_VAR9);
        lastBit = nineBit ? LAST_BIT_LONG : LAST_BIT_SHORT;
        // Mode 2 divides the system clock; modes 1 and 3 follow the timer tick
        subTick = (mode == MODE_FIX9) ? (s.subDiv == (doubleRate ? M2_DIV_FAST : M2_DIV_SLOW))
                                      : baudTick;
        next_s.subDiv = subTick ? 2'h0 : s.subDiv + 2'h1;
        syncLast = s.ctl[CTL_MP_EN] ? M0_LAST_FAST : M0_LAST_SLOW;
        syncHalf = s.ctl[CTL_MP_EN] ? M0_HALF_FAST : M0_HALF_SLOW;
        rxFinish = 1'b0;
        stopBit = rxdIn;
        ninthBit = nineBit ? s.rxShift[8] : rxdIn;
        rxWord = nineBit ? s.rxShift[7:0] : s.rxShift[8:1];
        addrOk = ((rxWord ^ s.slave) & s.mask) == 8'h00;
        accept = 1'b0;
        txStopEntry = 1'b0;
        next_s.rxPrev = rxdIn;

        // Bus read: data address returns the receive register only
        unique case (sfrAddr)
            ADDR_SLAVE: next_s.rdata = s.slave;
            ADDR_MASK: next_s.rdata = s.mask;
            ADDR_CONTROL: next_s.rdata = {frameErrSel ? s.frameErr : s.ctl[CTL_UPPER_MODE], s.ctl[6:0]};
            ADDR_DATA: next_s.rdata = s.rxData;
            default: next_s.rdata = REG_RESET;
        endcase
        if (!sfrRd)
        begin
            next_s.rdata = s.rdata;
        end

        // Bus writes come first so that hardware sets below win
        if (sfrWr && sfrAddr == ADDR_SLAVE)
        begin
            next_s.slave = sfrWdata;
        end
        if (sfrWr && sfrAddr == ADDR_MASK)
        begin
            next_s.mask = sfrWdata;
        end
        if (sfrWr && sfrAddr == ADDR_CONTROL)
        begin
            next_s.ctl[6:0] = sfrWdata[6:0];
            if (frameErrSel)
                next_s.frameErr = sfrWdata[7];
            else
                next_s.ctl[CTL_UPPER_MODE] = sfrWdata[7];
        end

        // Transmitter; a write while it is busy or while a mode 0 reception runs is dropped
        unique case (s.tx)
            TX_IDLE:
            begin
                if (sfrWr && sfrAddr == ADDR_DATA && s.rx != RX_SYNC)
                begin
                    next_s.txCnt = 4'h0;
                    next_s.txSub = 4'h0;
                    next_s.syncDiv = 4'h0;
                    next_s.txAct = 1'b1;
                    if (mode == MODE_SHIFT)
                    begin
                        next_s.tx = TX_SYNC;
                        next_s.txShift = {3'b111, sfrWdata};
                    end
                    else
                    begin
                        next_s.tx = TX_ASYNC;
                        next_s.txShift = {1'b1, nineBit ? s.ctl[CTL_TX_NINTH] : 1'b1, sfrWdata, 1'b0};
                    end
                end
            end
            TX_ASYNC:
            begin
                if (subTick)
                begin
                    next_s.txSub = s.txSub + 4'h1;
                    if (s.txSub == SUB_LAST)
                    begin
                        next_s.txShift = {1'b1, s.txShift[10:1]};
                        next_s.txCnt = s.txCnt + 4'h1;
                        if (s.txCnt + 4'h1 == lastBit)
                        begin
                            // Flag rises as the stop bit starts
                            txStopEntry = 1'b1;
                            next_s.ctl[CTL_TX_DONE] = 1'b1;
                            next_s.txAct = 1'b0;
                        end
                        if (s.txCnt == lastBit)
                        begin
                            next_s.tx = TX_IDLE;
                        end
                    end
                end
            end
            TX_SYNC:
            begin
                next_s.syncDiv = s.syncDiv + 4'h1;
                if (s.syncDiv == syncLast)
                begin
                    next_s.syncDiv = 4'h0;
                    next_s.txShift = {1'b1, s.txShift[10:1]};
                    next_s.txCnt = s.txCnt + 4'h1;
                    if (s.txCnt == SYNC_LAST)
                    begin
                        next_s.tx = TX_IDLE;
                        next_s.ctl[CTL_TX_DONE] = 1'b1;
                        next_s.txAct = 1'b0;
                    end
                end
            end
            default: next_s.tx = TX_IDLE;
        endcase

        // Receiver
        unique case (s.rx)
            RX_IDLE:
            begin
                next_s.rxCnt = 4'h0;
                next_s.rxSub = 4'h0;
                if (s.ctl[CTL_RX_EN])
                begin
                    if (mode != MODE_SHIFT && s.rxPrev && !rxdIn)
                    begin
                        next_s.rx = RX_ASYNC;
                        next_s.rxAct = 1'b1;
                    end
                    else if (mode == MODE_SHIFT && !s.ctl[CTL_RX_DONE] && s.tx == TX_IDLE)
                    begin
                        next_s.rx = RX_SYNC;
                        next_s.syncDiv = 4'h0;
                        next_s.rxAct = 1'b1;
                    end
                end
            end
            RX_ASYNC:
            begin
                if (subTick)
                begin
                    next_s.rxSub = s.rxSub + 4'h1;
                    if (s.rxSub == SAMPLE_POINT)
                    begin
                        next_s.rxCnt = s.rxCnt + 4'h1;
                        if (s.rxCnt == 4'h0 && rxdIn)
                        begin
                            // Glitch, not a start bit
                            next_s.rx = RX_IDLE;
                            next_s.rxAct = 1'b0;
                        end
                        else if (s.rxCnt != 4'h0 && s.rxCnt < lastBit)
                        begin
                            next_s.rxShift = {rxdIn, s.rxShift[8:1]};
                        end
                        else if (s.rxCnt == lastBit)
                        begin
                            rxFinish = 1'b1;
                        end
                    end
                end
                if (rxFinish)
                begin
                    // Mid stop bit: filter, then load and flag
                    accept = !s.ctl[CTL_RX_DONE] && (!s.ctl[CTL_MP_EN] ||
                             (nineBit ? (ninthBit && addrOk) : stopBit));
                    next_s.rx = RX_IDLE;
                    next_s.rxAct = 1'b0;
                    if (!stopBit)
                        next_s.frameErr = 1'b1;
                    if (accept)
                    begin
                        next_s.rxData = rxWord;
                        next_s.ctl[CTL_RX_NINTH] = ninthBit;
                        next_s.ctl[CTL_RX_DONE] = 1'b1;
                    end
                end
            end
            RX_SYNC:
            begin
                next_s.syncDiv = s.syncDiv + 4'h1;
                if (s.syncDiv == syncHalf)
                    next_s.rxShift = {rxdIn, s.rxShift[8:1]};
                if (s.syncDiv == syncLast)
                begin
                    next_s.syncDiv = 4'h0;
                    next_s.rxCnt = s.rxCnt + 4'h1;
                    if (s.rxCnt == SYNC_LAST)
                    begin
                        next_s.rx = RX_IDLE;
                        next_s.rxData = s.rxShift[8:1];
                        next_s.ctl[CTL_RX_DONE] = 1'b1;
                        next_s.rxAct = 1'b0;
                    end
                end
            end
            default: next_s.rx = RX_IDLE;
        endcase
        // Abort any reception as soon as enable drops
        if (!s.ctl[CTL_RX_EN] && s.rx != RX_IDLE && !rxFinish)
        begin
            next_s.rx = RX_IDLE;
            next_s.rxAct = 1'b0;
        end

        // Transmit pin: shift clock in mode 0, frame bits otherwise
        if (next_s.tx == TX_SYNC || next_s.rx == RX_SYNC)
            next_s.txdLine = (next_s.syncDiv >= syncHalf);
        else if (next_s.tx == TX_ASYNC)
            next_s.txdLine = next_s.txShift[0];
        else
            next_s.txdLine = 1'b1;
    end

    // ============================================================
    // State register
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.tx <= TX_IDLE;
            s.rx <= RX_IDLE;
            s.rxPrev <= 1'b1;
            s.txdLine <= 1'b1;
            s.txShift <= 11'h7FF;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ============================================================
    // Checks and coverage
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_mp_nine;
        rxFinish && nineBit && s.ctl[CTL_MP_EN] && !ninthBit && !s.ctl[CTL_RX_DONE] |=> !s.ctl[CTL_RX_DONE];
    endproperty
    a_mp_nine: assert property (p_mp_nine) else $error("flag raised on data frame");
    property p_mp_stop;
        rxFinish && mode == MODE_VAR8 && s.ctl[CTL_MP_EN] && !stopBit && !s.ctl[CTL_RX_DONE] |=> !s.ctl[CTL_RX_DONE];
    endproperty
    a_mp_stop: assert property (p_mp_stop) else $error("flag raised without stop");
    property p_frame_err;
        rxFinish && !stopBit |=> s.frameErr;
    endproperty
    a_frame_err: assert property (p_frame_err) else $error("framing error missed");
    property p_rx_off;
        !s.ctl[CTL_RX_EN] |=> s.rx == RX_IDLE;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("receiving while disabled");
    property p_tx_flag;
        txStopEntry |=> s.ctl[CTL_TX_DONE] && !s.txAct && s.tx == TX_ASYNC && s.txdLine;
    endproperty
    a_tx_flag: assert property (p_tx_flag) else $error("stop entry wrong");
    property p_ninth_tx;
        s.tx == TX_IDLE && sfrWr && sfrAddr == ADDR_DATA && nineBit && s.rx != RX_SYNC
            |=> s.txShift[9] == $past(s.ctl[CTL_TX_NINTH]);
    endproperty
    a_ninth_tx: assert property (p_ninth_tx) else $error("ninth bit not loaded");
    property p_buffer_split;
        sfrWr && sfrAddr == ADDR_DATA && s.rx == RX_IDLE |=> $stable(s.rxData);
    endproperty
    a_buffer_split: assert property (p_buffer_split) else $error("write hit receive data");
    property p_any_addr;
        rxFinish && nineBit && s.mask == 8'h00 && ninthBit && !s.ctl[CTL_RX_DONE] |=> s.ctl[CTL_RX_DONE];
    endproperty
    a_any_addr: assert property (p_any_addr) else $error("zero mask rejected");
    property p_rx_act;
        $rose(s.ctl[CTL_RX_DONE]) && !$past(sfrWr) |-> !s.rxAct;
    endproperty
    a_rx_act: assert property (p_rx_act) else $error("receive activity stuck");
    // Shift data may only move as a new bit period begins
    property p_sync_pin;
        s.tx == TX_SYNC && s.syncDiv != 4'h0 |-> rxdOe && $stable(rxdOut) && s.txCnt <= SYNC_LAST;
    endproperty
    a_sync_pin: assert property (p_sync_pin) else $error("shift data not driven");

    c_tx_async: cover property (s.tx == TX_ASYNC ##1 s.tx == TX_IDLE);
    c_rx_accept: cover property (rxFinish && accept);
    c_sync_tx: cover property (s.tx == TX_SYNC ##1 s.tx == TX_IDLE);
    c_sync_rx: cover property (s.rx == RX_SYNC ##1 s.rx == RX_IDLE);
endmodule : sspam_core

// ---- bench/sspam_peer.sv ----
// Remote serial node model: sends async frames on the receive pin, captures frames from the transmit pin
`timescale 1ns/1ps
module sspam_peer
#(
    parameter int BIT_CLKS = 32
)
(
    input wire logic clk_sys,
    input wire logic txdLine,
    output logic rxdDrive
);
    // ============================================================
    // Line idles high between frames, as a stopped UART does
    initial rxdDrive = 1'b1;

    // Start bit low, then bits LSB first, last bits are ninth and stop
    task automatic send(input int n, input logic [9:0] v);
        @(posedge clk_sys);
        rxdDrive <= 1'b0;
        repeat (BIT_CLKS) @(posedge clk_sys);
        for (int i = 0; i < n; i++)
        begin
            rxdDrive <= v[i];
            repeat (BIT_CLKS) @(posedge clk_sys);
        end
        rxdDrive <= 1'b1;
        repeat (BIT_CLKS) @(posedge clk_sys);
    endtask : send

    // Bounded hunt for a start edge, then centre sampling of n bits
    task automatic catch(input int n, output logic [9:0] v, output bit ok);
        ok = 1'b0;
        v = '0;
        for (int t = 0; t < 3000 && !ok; t++)
        begin
            @(posedge clk_sys);
            if (txdLine === 1'b0)
                ok = 1'b1;
        end
        if (ok)
        begin
            repeat (BIT_CLKS / 2) @(posedge clk_sys);
            for (int i = 0; i < n; i++)
            begin
                repeat (BIT_CLKS) @(posedge clk_sys);
                v[i] = txdLine;
            end
        end
    endtask : catch

    // Mode 0 slave: bit 0 waits on the pin, each later bit follows a falling shift clock
    task automatic shift_bits(input logic [7:0] v, output bit ok);
        logic prev;
        int k;
        k = 0;
        @(posedge clk_sys);
        rxdDrive <= v[0];
        prev = txdLine;
        for (int t = 0; t < 400 && k < 8; t++)
        begin
            @(posedge clk_sys);
            if (prev === 1'b1 && txdLine === 1'b0)
            begin
                // First fall opens the frame; later ones mean the last bit was taken
                if (k > 0)
                    rxdDrive <= v[k];
                k++;
            end
            prev = txdLine;
        end
        ok = (k == 8);
        // Hold the last bit past its sampling edge, then idle high again
        repeat (4) @(posedge clk_sys);
        rxdDrive <= 1'b1;
    endtask : shift_bits
endmodule : sspam_peer

// ---- bench/tb_top.sv ----
// Self-checking bench for the second serial port with address match
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin n_checks++; if ((ac) !== (ex)) begin errors++; \
    $display("ERROR %s expected %h seen %h", nm, ex, ac); end end
module tb_top;
    import sspam_pkg::*;
    // ============================================================
    // Clock, reset and design inputs
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sfrAddr = 8'h00;
    logic sfrWr = 1'b0;
    logic sfrRd = 1'b0;
    logic [7:0] sfrWdata = 8'h00;
    logic frameErrSel = 1'b0;
    logic doubleRate = 1'b1;
    logic baudTick = 1'b0;
    logic [7:0] sfrRdata;
    logic rxdOut, rxdOe, txdOut, txActive, rxActive, peerRxd, rxdLine;
    int errors = 0;
    int n_checks = 0;

    always #4 clk_sys = ~clk_sys;
    // Tick every other clock: 16 ticks give the same 32-clock bit as fast mode 2
    always @(posedge clk_sys) baudTick <= ~baudTick;
    // Receive pin level: block drives it only while its enable is high
    assign rxdLine = rxdOe ? rxdOut : peerRxd;

    sspam_core u_sspam_core (.clk_sys(clk_sys), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
        .sfrRd(sfrRd), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .frameErrSel(frameErrSel),
        .doubleRate(doubleRate), .baudTick(baudTick), .rxdIn(rxdLine), .rxdOut(rxdOut),
        .rxdOe(rxdOe), .txdOut(txdOut), .txActive(txActive), .rxActive(rxActive));
    sspam_peer #(.BIT_CLKS(32)) u_sspam_peer (.clk_sys(clk_sys), .txdLine(txdOut), .rxdDrive(peerRxd));

    // ============================================================
    // Register bus tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfrAddr <= a;
        sfrWdata <= d;
        sfrWr <= 1'b1;
        @(posedge clk_sys);
        sfrWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        sfrAddr <= a;
        sfrRd <= 1'b1;
        @(posedge clk_sys);
        sfrRd <= 1'b0;
        @(posedge clk_sys);
        #1 d = sfrRdata;
    endtask : rd

    // Bounded wait until both engines are quiet; n counts the clocks spent
    task automatic wait_quiet(output int n);
        n = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        while ((txActive !== 1'b0 || rxActive !== 1'b0) && n < 5000);
        if (txActive !== 1'b0 || rxActive !== 1'b0)
        begin
            errors++;
            $display("ERROR engine idle expected 0 seen %b", txActive | rxActive);
            close_out();
        end
    endtask : wait_quiet

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    // ============================================================
    // Scenarios
    task automatic sc_regs();
        logic [7:0] d;
        int n;
        rd(ADDR_CONTROL, d);
        `CHK("control reset", REG_RESET, d)
        rd(ADDR_MASK, d);
        `CHK("mask reset", REG_RESET, d)
        wr(ADDR_MASK, 8'hC3);
        // In mode 0 this write starts a clock/12 shift; it must end before the next scenario
        wr(ADDR_DATA, 8'h5C);
        wait_quiet(n);
        `CHK("slow shift time", 96, n)
        rd(ADDR_DATA, d);
        `CHK("rx data untouched", REG_RESET, d)
        rd(ADDR_MASK, d);
        `CHK("mask rw", 8'hC3, d)
        rd(8'h55, d);
        `CHK("unmapped read", 8'h00, d)
    endtask : sc_regs

    // Mode 0 at clock/4: shift clock on transmit pin, data out on receive pin
    task automatic sc_shift_tx();
        logic [7:0] d;
        logic prev;
        bit oe;
        int rises, first, last;
        rises = 0;
        oe = 0;
        prev = 1'b1;
        wr(ADDR_CONTROL, 8'h20);
        wr(ADDR_DATA, 8'h96);
        for (int t = 0; t < 120; t++)
        begin
            @(posedge clk_sys);
            #1;
            if (rxdOe === 1'b1)
                oe = 1;
            if (prev === 1'b0 && txdOut === 1'b1)
            begin
                d = {rxdOut, d[7:1]};
                if (rises == 0)
                    first = t;
                last = t;
                rises++;
            end
            prev = txdOut;
        end
        `CHK("shift oe", 1'b1, oe)
        `CHK("shift clocks", 8, rises)
        `CHK("shift period", 28, last - first)
        `CHK("shift data", 8'h96, d)
        rd(ADDR_CONTROL, d);
        `CHK("shift tx done", 1'b1, d[CTL_TX_DONE])
    endtask : sc_shift_tx

    // Mode 0 reception at clock/4: peer answers the shift clock on the receive pin
    task automatic sc_shift_rx();
        logic [7:0] d;
        bit ok;
        int n;
        fork
            u_sspam_peer.shift_bits(8'h4B, ok);
            wr(ADDR_CONTROL, 8'h30);
        join
        wait_quiet(n);
        `CHK("shift rx bits", 1'b1, ok)
        rd(ADDR_CONTROL, d);
        `CHK("shift rx done", 1'b1, d[CTL_RX_DONE])
        rd(ADDR_DATA, d);
        `CHK("shift rx data", 8'h4B, d)
    endtask : sc_shift_rx

    // Mode 2 fast transmit with ninth bit set
    task automatic sc_async_tx();
        logic [9:0] v;
        logic [7:0] d;
        bit ok;
        wr(ADDR_CONTROL, 8'h88);
        fork
            u_sspam_peer.catch(10, v, ok);
            begin
                wr(ADDR_DATA, 8'hA5);
                @(posedge clk_sys);
                #1 `CHK("tx active", 1'b1, txActive)
            end
        join
        `CHK("tx start seen", 1'b1, ok)
        `CHK("tx frame", 10'h3A5, v)
        rd(ADDR_CONTROL, d);
        `CHK("tx done", 1'b1, d[CTL_TX_DONE])
        `CHK("tx idle", 1'b0, txActive)
        if (!ok)
            close_out();
    endtask : sc_async_tx

    // Mode 2 and mode 3 multiprocessor reception through the address filter
    task automatic sc_addr_rx();
        logic [7:0] msk [4] = '{8'hF0, 8'hF0, 8'hF0, 8'h00};
        logic [9:0] frm [4] = '{10'h253, 10'h363, 10'h353, 10'h363};
        logic exp [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
        logic [7:0] d;
        wr(ADDR_SLAVE, 8'h5A);
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_MASK, msk[i]);
            // Last frame runs in mode 3 so the baud-tick nine-bit path is used too
            wr(ADDR_CONTROL, (i == 3) ? 8'hF0 : 8'hB0);
            u_sspam_peer.send(10, frm[i]);
            rd(ADDR_CONTROL, d);
            `CHK("filter rx done", exp[i], d[CTL_RX_DONE])
            `CHK("rx idle", 1'b0, rxActive)
            if (exp[i])
            begin
                `CHK("rx ninth", 1'b1, d[CTL_RX_NINTH])
                rd(ADDR_DATA, d);
                `CHK("rx data", frm[i][7:0], d)
            end
        end
    endtask : sc_addr_rx

    // Receiver disabled: a whole frame is ignored
    task automatic sc_rx_off();
        logic [7:0] d;
        wr(ADDR_CONTROL, 8'h80);
        u_sspam_peer.send(10, 10'h3C7);
        rd(ADDR_CONTROL, d);
        `CHK("rx off done", 1'b0, d[CTL_RX_DONE])
        rd(ADDR_DATA, d);
        `CHK("rx off data", 8'h63, d)
    endtask : sc_rx_off

    // Mode 1 on baud ticks with a bad stop bit, with and without filtering
    task automatic sc_frame_err();
        logic [7:0] d;
        wr(ADDR_CONTROL, 8'h70);
        @(posedge clk_sys);
        frameErrSel <= 1'b1;
        u_sspam_peer.send(9, 10'h03C);
        rd(ADDR_CONTROL, d);
        `CHK("fe filtered", 8'hF0, d)
        wr(ADDR_CONTROL, 8'h50);
        rd(ADDR_CONTROL, d);
        `CHK("fe cleared", 8'h50, d)
        u_sspam_peer.send(9, 10'h03C);
        rd(ADDR_CONTROL, d);
        `CHK("fe stop bit", 8'hD1, d)
        rd(ADDR_DATA, d);
        `CHK("mode1 data", 8'h3C, d)
    endtask : sc_frame_err

    // ============================================================
    // Main sequence: reset held 12 cycles, then each scenario in turn
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        sc_regs();
        sc_shift_tx();
        sc_shift_rx();
        sc_async_tx();
        sc_addr_rx();
        sc_rx_off();
        sc_frame_err();
        close_out();
    end
endmodule : tb_top
